// [pkg/input_router_consts.vh]
// Constants for the input function router: function codes, widths and
// power-up assignments. Assumes inclusion by the router design files only.
`ifndef INPUT_ROUTER_CONSTS_VH
`define INPUT_ROUTER_CONSTS_VH

`define TERM_COUNT 8
`define CODE_W 6
`define WR_CODE_W 8
`define FUNC_SPACE 64

`define CODE_NONE 6'h00
`define CODE_CONT_POS 6'h01
`define CODE_CONT_NEG 6'h02
`define CODE_HOME 6'h03
`define CODE_POSITIONING 6'h04
`define CODE_SEQ_POS 6'h05
`define CODE_JOG_POS 6'h06
`define CODE_JOG_NEG 6'h07
`define CODE_DIRECT_FIRST 6'h08
`define CODE_DIRECT_LAST 6'h0D
`define CODE_DE_EXCITE 6'h10
`define CODE_EXC_TOGGLE 6'h11
`define CODE_STOP 6'h12
`define CODE_ALARM_CLEAR 6'h18
`define CODE_POS_PRESET 6'h19
`define CODE_TOOL_RELEASE 6'h1B
`define CODE_GENERAL_FIRST 6'h20
`define CODE_GENERAL_LAST 6'h2F
`define CODE_SELECT_FIRST 6'h30
`define CODE_SELECT_LAST 6'h35

`define RST_ASSIGN_T0 `CODE_HOME
`define RST_ASSIGN_T1 `CODE_POSITIONING
`define RST_ASSIGN_T2 6'h30
`define RST_ASSIGN_T3 6'h31
`define RST_ASSIGN_T4 6'h32
`define RST_ASSIGN_T5 `CODE_DE_EXCITE
`define RST_ASSIGN_T6 `CODE_STOP
`define RST_ASSIGN_T7 `CODE_ALARM_CLEAR
`define RST_POLARITY 8'h00

`endif

// [rtl/input_sync.v]
// Two-stage synchroniser for a group of terminal levels.
// Assumes the levels may change at any time relative to ref_clk.
`timescale 1ns/1ps
module input_sync #(
   parameter WIDTH = 8
) (
   input wire ref_clk,
   input wire rst_n,
   input wire [WIDTH-1:0] asyncIn,
   output reg [WIDTH-1:0] syncOut_r
);

   reg [WIDTH-1:0] stage1_r;

   // The first stage feeds only the second stage, so a metastable value
   // never reaches decoding logic.
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         stage1_r <= {WIDTH{1'b0}};
         syncOut_r <= {WIDTH{1'b0}};
      end else begin
         stage1_r <= asyncIn;
         syncOut_r <= stage1_r;
      end
   end

endmodule

// [rtl/input_function_router.v]
// Routes eight direct input terminals and a network input image onto the
// internal command functions of a stepping-motor driver.
// Assumes configuration writes come from local firmware in the ref_clk domain.
//
// Functional notes
// - Per-terminal assignment number; zero means unused.
// - Terminals 0-3 reset to home, start, select0, select1.
// - Terminals 4-7 reset to select2, de-excite, stop, alarm.
// - Codes 1-5, 8-13 request motion operations.
// - Codes 6 and 7 request jog motion.
// - Code 16 removes excitation, releases brake.
// - Code 17 toggles excited and non-excited states.
// - Code 18 halts the motion in progress.
// - Code 24 clears alarm; 25 presets position.
// - Code 27 lifts tool function restrictions.
// - Codes 32-47 map sixteen general network bits.
// - Codes 48-53 map six data select bits.
// - Duplicate assignments combine as logical OR.
// - Alarm clear and preset act on rising edge.
// - Unassigned tool release stays permanently active.
// - Direct and network tool release combine by AND.
// - Commands come from terminals and network image.
// - Per-terminal polarity; one inverts, reset zero.
`timescale 1ns/1ps
`include "input_router_consts.vh"
module input_function_router #(
   parameter TERMS = `TERM_COUNT
) (
   input wire ref_clk,
   input wire rst_n,
   input wire [TERMS-1:0] inputTerminal,
   input wire [`FUNC_SPACE-1:0] netImage,
   input wire netToolAssigned,
   input wire assignWrEn,
   input wire [2:0] assignWrSel,
   input wire [`WR_CODE_W-1:0] assignWrCode,
   input wire polarityWrEn,
   input wire [2:0] polarityWrSel,
   input wire polarityWrVal,
   input wire [2:0] cfgRdSel,
   output reg [`CODE_W-1:0] assignRdCode_r,
   output reg polarityRd_r,
   output reg assignReject_r,
   output reg [TERMS-1:0] termLevel_r,
   output reg continuousPositiveCmd_r,
   output reg continuousNegativeCmd_r,
   output reg homeCmd_r,
   output reg positioningCmd_r,
   output reg sequentialPositioningCmd_r,
   output reg jogPositiveCmd_r,
   output reg jogNegativeCmd_r,
   output reg [5:0] directPositionCmd_r,
   output reg deExciteCmd_r,
   output reg excitationToggle_r,
   output reg stopCmd_r,
   output reg alarmClear_r,
   output reg positionPreset_r,
   output reg toolRestrictionRelease_r,
   output reg [15:0] generalBit_r,
   output reg [5:0] dataSelectBit_r
);

   // True for every code that the assignment table lists, zero included.
   // Each code is spelt out so that a gap in the table cannot slip in.
   function isValidCode;
      input [`WR_CODE_W-1:0] code;
      begin
         case (code)
            8'h00,
            8'h01,
            8'h02,
            8'h03,
            8'h04,
            8'h05,
            8'h06,
            8'h07,
            8'h08,
            8'h09,
            8'h0A,
            8'h0B,
            8'h0C,
            8'h0D,
            8'h10,
            8'h11,
            8'h12,
            8'h18,
            8'h19,
            8'h1B,
            8'h20,
            8'h21,
            8'h22,
            8'h23,
            8'h24,
            8'h25,
            8'h26,
            8'h27,
            8'h28,
            8'h29,
            8'h2A,
            8'h2B,
            8'h2C,
            8'h2D,
            8'h2E,
            8'h2F,
            8'h30,
            8'h31,
            8'h32,
            8'h33,
            8'h34,
            8'h35: isValidCode = 1'b1;
            default: isValidCode = 1'b0;
         endcase
      end
   endfunction

   // One-cycle pulse on an inactive-to-active transition.
   function risingEdge;
      input level;
      input prevLevel;
      begin
         risingEdge = level & ~prevLevel;
      end
   endfunction

   // Power-up assignment of each terminal.
   function [`CODE_W-1:0] resetCode;
      input integer term;
      begin
         case (term[2:0])
            3'h0: resetCode = `RST_ASSIGN_T0;
            3'h1: resetCode = `RST_ASSIGN_T1;
            3'h2: resetCode = `RST_ASSIGN_T2;
            3'h3: resetCode = `RST_ASSIGN_T3;
            3'h4: resetCode = `RST_ASSIGN_T4;
            3'h5: resetCode = `RST_ASSIGN_T5;
            3'h6: resetCode = `RST_ASSIGN_T6;
            3'h7: resetCode = `RST_ASSIGN_T7;
            default: resetCode = `CODE_NONE;
         endcase
      end
   endfunction

   reg [`CODE_W-1:0] assign_r [0:TERMS-1];
   reg [TERMS-1:0] polarity_r;
   reg alarmPrev_r;
   reg presetPrev_r;
   wire [TERMS-1:0] syncLevel;
   wire [TERMS-1:0] activeLevel;
   reg [`FUNC_SPACE-1:0] funcDirect;
   reg toolAssigned;
   wire [`FUNC_SPACE-1:0] funcMerged;
   reg toolRelease_nxt;
   wire alarmLevel;
   wire presetLevel;
   integer t;
   genvar g;

   input_sync #(
      .WIDTH(TERMS)
   ) termSync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .asyncIn(inputTerminal),
      .syncOut_r(syncLevel)
   );

   // A normally-closed terminal reports active when its contact opens.
   assign activeLevel = syncLevel ^ polarity_r;

   // Assignment table, one entry per terminal.
   generate
      for (g = 0; g < TERMS; g = g + 1) begin : gAssign
         always @(posedge ref_clk) begin
            if (!rst_n) begin
               assign_r[g] <= resetCode(g);
            end else if (assignWrEn && {29'h0, assignWrSel} == g) begin
               // An unlisted code leaves the old entry so a bad write is harmless.
               if (isValidCode(assignWrCode)) begin
                  assign_r[g] <= assignWrCode[`CODE_W-1:0];
               end
            end
         end
      end
   endgenerate

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         polarity_r <= `RST_POLARITY;
      end else if (polarityWrEn) begin
         polarity_r[polarityWrSel] <= polarityWrVal;
      end
   end

   // Reject flag stands one cycle after each refused write.
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         assignReject_r <= 1'b0;
      end else begin
         assignReject_r <= assignWrEn && !isValidCode(assignWrCode);
      end
   end

   // Readback is registered so cfgRdSel may change freely; the value lags one cycle.
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         assignRdCode_r <= `CODE_NONE;
      end else begin
         assignRdCode_r <= assign_r[cfgRdSel];
      end
   end

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         polarityRd_r <= 1'b0;
      end else begin
         polarityRd_r <= polarity_r[cfgRdSel];
      end
   end

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         termLevel_r <= {TERMS{1'b0}};
      end else begin
         termLevel_r <= activeLevel;
      end
   end

   // Build the direct function image. Several terminals on one code simply
   // OR together; code zero is discarded so unused terminals drive nothing.
   always @* begin
      funcDirect = {`FUNC_SPACE{1'b0}};
      toolAssigned = 1'b0;
      for (t = 0; t < TERMS; t = t + 1) begin
         if (activeLevel[t]) begin
            funcDirect[assign_r[t]] = 1'b1;
         end
         if (assign_r[t] == `CODE_TOOL_RELEASE) begin
            toolAssigned = 1'b1;
         end
      end
      funcDirect[`CODE_NONE] = 1'b0;
   end

   // Both sources feed every function; only tool release is combined
   // differently below.
   assign funcMerged = funcDirect | netImage;

   // Tool release defaults on so that the setting tools keep working when
   // nobody wires the terminal; with two sources both must agree.
   always @* begin
      if (!toolAssigned) begin
         toolRelease_nxt = 1'b1;
      end else if (netToolAssigned) begin
         toolRelease_nxt = funcDirect[`CODE_TOOL_RELEASE] & netImage[`CODE_TOOL_RELEASE];
      end else begin
         toolRelease_nxt = funcDirect[`CODE_TOOL_RELEASE];
      end
   end

   assign alarmLevel = funcMerged[`CODE_ALARM_CLEAR];
   assign presetLevel = funcMerged[`CODE_POS_PRESET];

   // Alarm clear and preset are edge actions; a held level would otherwise
   // keep clearing alarms or re-zeroing the counter every cycle.
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         alarmPrev_r <= 1'b0;
         presetPrev_r <= 1'b0;
         alarmClear_r <= 1'b0;
         positionPreset_r <= 1'b0;
      end else begin
         alarmPrev_r <= alarmLevel;
         presetPrev_r <= presetLevel;
         alarmClear_r <= risingEdge(alarmLevel, alarmPrev_r);
         positionPreset_r <= risingEdge(presetLevel, presetPrev_r);
      end
   end

   // Motion requests follow their merged level.
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         continuousPositiveCmd_r <= 1'b0;
         continuousNegativeCmd_r <= 1'b0;
         homeCmd_r <= 1'b0;
         positioningCmd_r <= 1'b0;
         sequentialPositioningCmd_r <= 1'b0;
         jogPositiveCmd_r <= 1'b0;
         jogNegativeCmd_r <= 1'b0;
         directPositionCmd_r <= 6'h00;
      end else begin
         continuousPositiveCmd_r <= funcMerged[`CODE_CONT_POS];
         continuousNegativeCmd_r <= funcMerged[`CODE_CONT_NEG];
         homeCmd_r <= funcMerged[`CODE_HOME];
         positioningCmd_r <= funcMerged[`CODE_POSITIONING];
         sequentialPositioningCmd_r <= funcMerged[`CODE_SEQ_POS];
         jogPositiveCmd_r <= funcMerged[`CODE_JOG_POS];
         jogNegativeCmd_r <= funcMerged[`CODE_JOG_NEG];
         directPositionCmd_r <= funcMerged[`CODE_DIRECT_LAST:`CODE_DIRECT_FIRST];
      end
   end

   // Excitation, stop and tool release. Tool release resets high so the
   // setting tools are usable straight after power-up.
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         deExciteCmd_r <= 1'b0;
         excitationToggle_r <= 1'b0;
         stopCmd_r <= 1'b0;
         toolRestrictionRelease_r <= 1'b1;
      end else begin
         deExciteCmd_r <= funcMerged[`CODE_DE_EXCITE];
         excitationToggle_r <= funcMerged[`CODE_EXC_TOGGLE];
         stopCmd_r <= funcMerged[`CODE_STOP];
         toolRestrictionRelease_r <= toolRelease_nxt;
      end
   end

   // General bits and data selection; terminals may feed them as well as the
   // network image.
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         generalBit_r <= 16'h0000;
         dataSelectBit_r <= 6'h00;
      end else begin
         generalBit_r <= funcMerged[`CODE_GENERAL_LAST:`CODE_GENERAL_FIRST];
         dataSelectBit_r <= funcMerged[`CODE_SELECT_LAST:`CODE_SELECT_FIRST];
      end
   end

endmodule

// [verif/switch_panel.sv]
// Far-side model: field switches on the eight terminals and the host's network image.
// Assumes the bench changes its commands just after a clock edge.
`timescale 1ns/1ps
module switch_panel (
   input wire [7:0] pressed,
   input wire [7:0] normallyClosed,
   input wire [63:0] hostImage,
   output wire [7:0] inputTerminal,
   output wire [63:0] netImage
);
   // A normally-closed contact reads high until it is pressed.
   assign inputTerminal = pressed ^ normallyClosed;
   assign netImage = hostImage;
endmodule

// [verif/input_function_router_monitor.sv]
// Checker for the input function router, bound to its top module.
// Assumes the port names and widths of the router design.
`timescale 1ns/1ps
module input_function_router_monitor (
   input wire ref_clk,
   input wire rst_n,
   input wire [63:0] netImage,
   input wire assignWrEn,
   input wire [2:0] assignWrSel,
   input wire [7:0] assignWrCode,
   input wire [2:0] cfgRdSel,
   input wire [5:0] assignRdCode_r,
   input wire assignReject_r,
   input wire jogPositiveCmd_r,
   input wire excitationToggle_r,
   input wire alarmClear_r,
   input wire positionPreset_r,
   input wire [15:0] generalBit_r,
   input wire [5:0] dataSelectBit_r
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   chk_bad_code_flag: assert property (assignWrEn && assignWrCode == 8'h0E |=> assignReject_r)
      else $error("refused code not flagged");
   chk_good_code_quiet: assert property (assignWrEn && assignWrCode == 8'h08 |=> !assignReject_r)
      else $error("valid code flagged");
   chk_assign_readback: assert property (assignWrEn && assignWrCode == 8'h08 &&
      cfgRdSel == assignWrSel |=> ##[0:1] assignRdCode_r == 6'h08)
      else $error("assignment readback wrong");
   chk_alarm_one_pulse: assert property (alarmClear_r |=> !alarmClear_r)
      else $error("alarm clear longer than one cycle");
   chk_preset_one_pulse: assert property (positionPreset_r |=> !positionPreset_r)
      else $error("preset longer than one cycle");
   chk_net_jog: assert property (netImage[6] |=> jogPositiveCmd_r)
      else $error("network jog not routed");
   chk_net_toggle: assert property (netImage[17] |=> excitationToggle_r)
      else $error("network excitation toggle not routed");
   chk_net_general: assert property (netImage[33] |=> generalBit_r[1])
      else $error("network general bit not routed");
   chk_net_select: assert property (netImage[51] |=> dataSelectBit_r[3])
      else $error("network select bit not routed");
   cover property (alarmClear_r);
   cover property (positionPreset_r);
   cover property (assignReject_r);
endmodule
bind input_function_router input_function_router_monitor i_input_function_router_monitor (
   .ref_clk(ref_clk), .rst_n(rst_n), .netImage(netImage), .assignWrEn(assignWrEn),
   .assignWrSel(assignWrSel), .assignWrCode(assignWrCode), .cfgRdSel(cfgRdSel),
   .assignRdCode_r(assignRdCode_r), .assignReject_r(assignReject_r),
   .jogPositiveCmd_r(jogPositiveCmd_r), .excitationToggle_r(excitationToggle_r),
   .alarmClear_r(alarmClear_r), .positionPreset_r(positionPreset_r),
   .generalBit_r(generalBit_r), .dataSelectBit_r(dataSelectBit_r));

// [verif/input_function_router_tb_top.sv]
// Self-checking bench for the input function router with a switch and host model.
// Assumes the design's fixed latency of three edges from terminal to command.
`timescale 1ns/1ps
module input_function_router_tb_top;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] pressed = 8'h00, normallyClosed = 8'h00, wrCode = 8'h00, inputTerminal;
   logic [63:0] hostImage = 64'h0, netImage;
   logic netToolAssigned = 1'b0, assignWrEn = 1'b0, polarityWrEn = 1'b0, polarityWrVal = 1'b0;
   logic [2:0] assignWrSel = 3'h0, polarityWrSel = 3'h0, cfgRdSel = 3'h0;
   logic [5:0] assignRdCode_r, directPositionCmd_r, dataSelectBit_r;
   logic [7:0] termLevel_r;
   logic [15:0] generalBit_r;
   logic polarityRd_r, assignReject_r, cpos, cneg, home, posn, seqp, jpos, jneg, deExc, excTog;
   logic stopCmd_r, alarmClear_r, positionPreset_r, toolRestrictionRelease_r;
   int mismatches = 0, samplesChecked = 0, pulses;
   logic [5:0] rstCode [8] = '{6'h03, 6'h04, 6'h30, 6'h31, 6'h32, 6'h10, 6'h12, 6'h18};
   logic [7:0] badCode [9] = '{8'h0E, 8'h0F, 8'h13, 8'h17, 8'h1A, 8'h1C, 8'h1F, 8'h36, 8'hFF};
   switch_panel i_switch_panel (.pressed(pressed), .normallyClosed(normallyClosed),
      .hostImage(hostImage), .inputTerminal(inputTerminal), .netImage(netImage));
   input_function_router i_input_function_router (.ref_clk(ref_clk), .rst_n(rst_n),
      .inputTerminal(inputTerminal), .netImage(netImage), .netToolAssigned(netToolAssigned),
      .assignWrEn(assignWrEn), .assignWrSel(assignWrSel), .assignWrCode(wrCode),
      .polarityWrEn(polarityWrEn), .polarityWrSel(polarityWrSel), .polarityWrVal(polarityWrVal),
      .cfgRdSel(cfgRdSel), .assignRdCode_r(assignRdCode_r), .polarityRd_r(polarityRd_r),
      .assignReject_r(assignReject_r), .termLevel_r(termLevel_r),
      .continuousPositiveCmd_r(cpos), .continuousNegativeCmd_r(cneg), .homeCmd_r(home),
      .positioningCmd_r(posn), .sequentialPositioningCmd_r(seqp), .jogPositiveCmd_r(jpos),
      .jogNegativeCmd_r(jneg), .directPositionCmd_r(directPositionCmd_r),
      .deExciteCmd_r(deExc), .excitationToggle_r(excTog), .stopCmd_r(stopCmd_r),
      .alarmClear_r(alarmClear_r), .positionPreset_r(positionPreset_r),
      .toolRestrictionRelease_r(toolRestrictionRelease_r), .generalBit_r(generalBit_r),
      .dataSelectBit_r(dataSelectBit_r));
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samplesChecked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Enable is lowered a full cycle before the next write so no edge sees a glitch.
   task automatic wr_assign(input logic [2:0] t, input logic [7:0] c);
      assignWrSel = t;
      wrCode = c;
      assignWrEn = 1'b1;
      tick(1);
      assignWrEn = 1'b0;
      tick(1);
   endtask
   task automatic press(input logic [7:0] p);
      pressed = p;
      tick(5);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samplesChecked, mismatches);
      if (mismatches == 0 && samplesChecked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge ref_clk);
      mismatches++;
      complete_run();
   end
   initial begin
      tick(5);
      rst_n = 1'b1;
      for (int i = 0; i < 8; i++) begin
         cfgRdSel = 3'(i);
         tick(2);
         chk("assignment", 16'(rstCode[i]), 16'(assignRdCode_r));
         chk("polarity", 16'h0, 16'(polarityRd_r));
      end
      chk("tool release", 16'h1, 16'(toolRestrictionRelease_r));
      $display("test reset done");
      press(8'h41);
      chk("home stop", 16'h3, 16'({home, stopCmd_r}));
      press(8'h00);
      pressed = 8'h80;
      pulses = 0;
      for (int k = 0; k < 8; k++) begin
         tick(1);
         pulses += (alarmClear_r === 1'b1);
      end
      chk("alarm pulses", 16'h1, 16'(pulses));
      press(8'h00);
      $display("test defaults done");
      cfgRdSel = 3'h0;
      for (int i = 0; i < 9; i++) wr_assign(3'h0, badCode[i]);
      chk("kept", 16'h3, 16'(assignRdCode_r));
      wr_assign(3'h0, 8'h00);
      press(8'h01);
      chk("unused", 16'h0, 16'(home));
      wr_assign(3'h1, 8'h12);
      press(8'h02);
      chk("stop dup", 16'h1, 16'(stopCmd_r));
      cfgRdSel = 3'h2;
      wr_assign(3'h2, 8'h08);
      press(8'h04);
      chk("direct", 16'h1, 16'(directPositionCmd_r));
      $display("test assignment done");
      normallyClosed = 8'h20;
      polarityWrSel = 3'h5;
      polarityWrVal = 1'b1;
      polarityWrEn = 1'b1;
      tick(1);
      polarityWrEn = 1'b0;
      cfgRdSel = 3'h5;
      press(8'h00);
      chk("nc idle", 16'h0, 16'(deExc));
      chk("polarity set", 16'h1, 16'(polarityRd_r));
      press(8'h20);
      chk("de-excite", 16'h1, 16'(deExc));
      chk("term level", 16'h20, 16'(termLevel_r));
      wr_assign(3'h3, 8'h1B);
      netToolAssigned = 1'b1;
      press(8'h08);
      chk("tool and", 16'h0, 16'(toolRestrictionRelease_r));
      hostImage[27] = 1'b1;
      press(8'h08);
      chk("tool both", 16'h1, 16'(toolRestrictionRelease_r));
      press(8'h00);
      chk("tool off", 16'h0, 16'(toolRestrictionRelease_r));
      $display("test polarity tool done");
      hostImage = 64'h0008_0002_0202_10F6;
      pulses = 0;
      for (int k = 0; k < 8; k++) begin
         tick(1);
         pulses += (positionPreset_r === 1'b1);
      end
      chk("preset pulses", 16'h1, 16'(pulses));
      chk("positioning", 16'h1, 16'(posn));
      chk("motion", 16'h3F, 16'({cpos, cneg, seqp, jpos, jneg, excTog}));
      chk("general", 16'h0002, generalBit_r);
      chk("select", 16'h08, 16'(dataSelectBit_r));
      hostImage = 64'h0;
      press(8'h00);
      $display("test network done");
      complete_run();
   end
endmodule
